// [verilog/pio_pkg.sv]
/*
  Shared constants and carrier types for the module I/O front end:
  timing counts, boot switch codes, pin bundle layout, bus records.
  Assumes a single 40 MHz reference clock for every block that imports it.
*/
package pio_pkg;

  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
  localparam int PWM_FREQ_HZ     = 2500;
  localparam int PWM_PERIOD_CYC  = CLK_HZ / PWM_FREQ_HZ;
  localparam logic [13:0] AO_FULL_SCALE = 14'h2710;
  localparam int ADC_BITS        = 10;
  localparam int NUM_DIO         = 16;
  localparam int NUM_DRV         = 3;
  localparam int NUM_EXT_CS      = 4;

  // reset output held low at least this long after our own reset ends
  localparam int RSTOUT_US       = 100;
  localparam int RSTOUT_CYC      = RSTOUT_US * CLK_MHZ;

  // extension bus phase lengths, in clock cycles
  localparam logic [2:0] EXT_ADDR_CYC   = 3'h2;
  localparam logic [2:0] EXT_HOLD_CYC   = 3'h1;
  localparam logic [2:0] EXT_STROBE_CYC = 3'h4;

  // serial clock half period: 400 kHz, safe for card initialisation
  localparam logic [5:0] SPI_HALF_CYC = 6'h32;
  localparam logic [4:0] SPI_EDGES    = 5'h10;

  // boot switch codes, bit 0 first switch bit
  localparam logic [3:0] BOOT_POS_0 = 4'hF;
  localparam logic [3:0] BOOT_POS_1 = 4'hE;
  localparam logic [3:0] BOOT_POS_E = 4'h1;
  localparam logic [3:0] BOOT_POS_F = 4'h0;
  localparam logic [1:0] BOOT_SETTLE_CYC = 2'h3;

  // synchronised pin bundle layout
  localparam int SY_DIN   = 0;
  localparam int SY_POLI  = 16;
  localparam int SY_POLO  = 17;
  localparam int SY_OVL   = 18;
  localparam int SY_PF    = 19;
  localparam int SY_CD    = 20;
  localparam int SY_BOOT  = 23;
  localparam int SY_UPD   = 27;
  localparam int SY_MISO  = 28;
  localparam int SY_AD    = 29;
  localparam int SY_W     = 37;
  // active-low pins rest high so reset does not fake an event
  localparam logic [SY_W-1:0] SYNC_RST = 37'h00007C0000;

  typedef struct packed {
    logic known;
    logic drive_c;
    logic loader_only;
  } pio_boot_t;

  typedef struct packed {
    logic        start;
    logic        write;
    logic [1:0]  cs;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } pio_ext_req_t;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] rdata;
  } pio_ext_rsp_t;

endpackage

// [verilog/pio_pwm.sv]
/*
  One analog output channel as a fixed-frequency PWM.
  Assumes value is a 0..10000 setting held by same-clock logic.
*/
`timescale 1ns/100ps
module pio_pwm
  import pio_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [13:0] value,
  output logic             pwm
);

  logic [13:0] cnt_r;
  logic [13:0] high_r;
  logic [13:0] high_nxt;
  logic [13:0] clamped;
  logic [27:0] prod;

  always_comb begin
    clamped  = (value > AO_FULL_SCALE) ? AO_FULL_SCALE : value;
    prod     = 28'(AO_FULL_SCALE - clamped) * 28'(PWM_PERIOD_CYC);
    high_nxt = 14'(prod / 28'(AO_FULL_SCALE));
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= 14'h0000;
      high_r <= 14'h0000;
    end else if (cnt_r == 14'(PWM_PERIOD_CYC - 1)) begin
      cnt_r  <= 14'h0000;
      // new value only at period start, so no runt pulses
      high_r <= high_nxt;
    end else begin
      cnt_r <= cnt_r + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (cnt_r < high_r);
    end
  end

endmodule

// [verilog/pio_front.sv]
/*
  Digital I/O front end of the controller module: strapped polarity
  inputs and outputs, driver enable, overload and power-fail sensing,
  reset output, two PWM analog outputs, converter result capture,
  multiplexed extension bus, shared card serial bus, boot switch decode.
  Assumes firmware logic on ref_clk drives the request ports, and board
  pins arrive asynchronous; the testbench resolves pin wires from *_oe.
*/
`timescale 1ns/100ps
module pio_front
  import pio_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  output logic                     pins_oe,
  input  wire logic [NUM_DIO-1:0]  digital_input_line,
  input  wire logic                input_polarity_strap,
  output logic [NUM_DIO-1:0]       din_active,
  input  wire logic [NUM_DIO-1:0]  dout_value,
  input  wire logic                output_polarity_strap,
  output logic [NUM_DIO-1:0]       digital_output_line,
  input  wire logic                driver_on,
  output logic                     driver_enable_n,
  input  wire logic                overload_sense_n,
  input  wire logic                overload_clr,
  output logic                     overload_flag,
  input  wire logic                power_fail_n,
  input  wire logic                power_fail_ack,
  output logic                     power_fail_req,
  output logic                     power_fail_flag,
  output logic                     reset_out_n,
  input  wire logic [13:0]         ao_value_0,
  input  wire logic [13:0]         ao_value_1,
  output logic                     analog_out_pwm_0,
  output logic                     analog_out_pwm_1,
  input  wire logic [ADC_BITS-1:0] analog_input_0,
  input  wire logic [ADC_BITS-1:0] analog_input_1,
  input  wire logic                adc_strobe,
  output logic [ADC_BITS-1:0]      adc_result_0,
  output logic [ADC_BITS-1:0]      adc_result_1,
  output logic                     adc_ready,
  input  wire logic                update_strap,
  output logic                     update_mode,
  input  wire pio_ext_req_t        ext_req,
  output pio_ext_rsp_t             ext_rsp,
  input  wire logic [7:0]          ext_addr_data_bus_i,
  output logic [7:0]               ext_addr_data_bus_o,
  output logic                     ext_addr_data_bus_oe,
  output logic [3:0]               ext_upper_addr,
  output logic                     ext_ale,
  output logic                     ext_read_n,
  output logic                     ext_write_n,
  output logic [NUM_EXT_CS-1:0]    ext_cs_n,
  input  wire logic [2:0]          led_user,
  output logic [5:0]               led_n,
  input  wire logic [NUM_DRV-1:0]  drive_sel,
  output logic [NUM_DRV-1:0]       drive_select_n,
  input  wire logic [NUM_DRV-1:0]  drive_card_detect,
  output logic [NUM_DRV-1:0]       card_present,
  input  wire logic                spi_start,
  input  wire logic [7:0]          spi_tx,
  output logic [7:0]               spi_rx,
  output logic                     spi_busy,
  output logic                     spi_done,
  output logic                     sd_serial_clock,
  output logic                     sd_serial_out,
  input  wire logic                sd_serial_in,
  input  wire logic [3:0]          boot_switch,
  output pio_boot_t                boot_info
);

  // lowest requested drive wins; one select at a time on the shared bus
  function automatic logic [NUM_DRV-1:0] pick_drive(input logic [NUM_DRV-1:0] req);
    pick_drive = req & (~req + 3'h1);
  endfunction

  function automatic pio_boot_t boot_decode(input logic [3:0] sw);
    pio_boot_t b;
    b.known = 1'b1;
    case (sw)
      BOOT_POS_0: begin b.drive_c = 1'b0; b.loader_only = 1'b0; end
      BOOT_POS_1: begin b.drive_c = 1'b1; b.loader_only = 1'b0; end
      BOOT_POS_E: begin b.drive_c = 1'b0; b.loader_only = 1'b1; end
      BOOT_POS_F: begin b.drive_c = 1'b1; b.loader_only = 1'b1; end
      default:    begin b.drive_c = 1'b0; b.loader_only = 1'b0; end
    endcase
    boot_decode = b;
  endfunction

  typedef enum logic [2:0] {EX_IDLE, EX_ADDR, EX_HOLD, EX_STROBE, EX_END} pio_ext_st_t;

  logic [SY_W-1:0] meta_r;
  logic [SY_W-1:0] sync_r;
  logic [SY_W-1:0] raw;
  logic            pf_prev_r;
  logic [12:0]     rst_cnt_r;
  logic [1:0]      boot_wait_r;
  pio_ext_st_t     ex_st_r;
  logic [2:0]      ex_ph_r;
  pio_ext_req_t    ex_req_r;
  logic [5:0]      spi_div_r;
  logic [4:0]      spi_edge_r;
  logic [7:0]      spi_txsh_r;
  logic [7:0]      spi_rxsh_r;
  logic [NUM_DRV-1:0] sel_nxt;
  logic            pwm0;
  logic            pwm1;

  assign raw = {ext_addr_data_bus_i, sd_serial_in, update_strap, boot_switch,
                drive_card_detect, power_fail_n, overload_sense_n,
                output_polarity_strap, input_polarity_strap, digital_input_line};

  // two-stage synchroniser for every board input except analog_input_0/1, which are captured directly on adc_strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_oe <= 1'b0;
    end else begin
      pins_oe <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      din_active <= 16'h0000;
    end else if (sync_r[SY_POLI]) begin
      din_active <= sync_r[SY_DIN +: NUM_DIO];
    end else begin
      din_active <= ~sync_r[SY_DIN +: NUM_DIO];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      digital_output_line <= 16'h0000;
    end else if (sync_r[SY_POLO]) begin
      digital_output_line <= dout_value;
    end else begin
      digital_output_line <= ~dout_value;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      driver_enable_n <= 1'b1;
    end else begin
      driver_enable_n <= ~driver_on;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      overload_flag <= 1'b0;
    end else if (!sync_r[SY_OVL]) begin
      overload_flag <= 1'b1;
    end else if (overload_clr) begin
      overload_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf_prev_r       <= 1'b1;
      power_fail_req  <= 1'b0;
      power_fail_flag <= 1'b0;
    end else begin
      pf_prev_r      <= sync_r[SY_PF];
      power_fail_req <= pf_prev_r & ~sync_r[SY_PF];
      if (pf_prev_r & ~sync_r[SY_PF]) begin
        power_fail_flag <= 1'b1;
      end else if (power_fail_ack) begin
        power_fail_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_r   <= 13'h0000;
      reset_out_n <= 1'b0;
    end else if (rst_cnt_r == 13'(RSTOUT_CYC - 1)) begin
      reset_out_n <= 1'b1;
    end else begin
      rst_cnt_r <= rst_cnt_r + 13'h0001;
    end
  end

  pio_pwm u_pwm0 (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .value   (ao_value_0),
    .pwm     (pwm0)
  );

  pio_pwm u_pwm1 (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .value   (ao_value_1),
    .pwm     (pwm1)
  );

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_out_pwm_0 <= 1'b0;
      analog_out_pwm_1 <= 1'b0;
    end else begin
      analog_out_pwm_0 <= pwm0;
      analog_out_pwm_1 <= pwm1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_result_0 <= 10'h000;
      adc_result_1 <= 10'h000;
      adc_ready    <= 1'b0;
    end else begin
      adc_ready <= adc_strobe;
      if (adc_strobe) begin
        adc_result_0 <= analog_input_0;
        adc_result_1 <= analog_input_1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      update_mode <= 1'b0;
    end else begin
      update_mode <= sync_r[SY_UPD];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_wait_r <= 2'h0;
      boot_info   <= '0;
    end else if (boot_wait_r != BOOT_SETTLE_CYC) begin
      boot_wait_r <= boot_wait_r + 2'h1;
    end else if (!boot_info.known) begin
      boot_info <= boot_decode(sync_r[SY_BOOT +: 4]);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ex_st_r  <= EX_IDLE;
      ex_ph_r  <= 3'h0;
      ex_req_r <= '0;
    end else begin
      case (ex_st_r)
        EX_IDLE: begin
          if (ext_req.start) begin
            ex_req_r <= ext_req;
            ex_ph_r  <= EXT_ADDR_CYC - 3'h1;
            ex_st_r  <= EX_ADDR;
          end
        end
        EX_ADDR: begin
          if (ex_ph_r == 3'h0) begin
            ex_ph_r <= EXT_HOLD_CYC - 3'h1;
            ex_st_r <= EX_HOLD;
          end else begin
            ex_ph_r <= ex_ph_r - 3'h1;
          end
        end
        EX_HOLD: begin
          if (ex_ph_r == 3'h0) begin
            ex_ph_r <= EXT_STROBE_CYC - 3'h1;
            ex_st_r <= EX_STROBE;
          end else begin
            ex_ph_r <= ex_ph_r - 3'h1;
          end
        end
        EX_STROBE: begin
          if (ex_ph_r == 3'h0) begin
            ex_st_r <= EX_END;
          end else begin
            ex_ph_r <= ex_ph_r - 3'h1;
          end
        end
        EX_END:  ex_st_r <= EX_IDLE;
        default: ex_st_r <= EX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_ale              <= 1'b0;
      ext_addr_data_bus_o  <= 8'h00;
      ext_addr_data_bus_oe <= 1'b0;
      ext_upper_addr       <= 4'h0;
      ext_read_n           <= 1'b1;
      ext_write_n          <= 1'b1;
      ext_cs_n             <= 4'hF;
      ext_rsp              <= '0;
    end else begin
      ext_rsp.done <= (ex_st_r == EX_END);
      ext_rsp.busy <= (ex_st_r != EX_IDLE) || ext_req.start;
      case (ex_st_r)
        EX_ADDR: begin
          ext_ale              <= 1'b1;
          ext_addr_data_bus_o  <= ex_req_r.addr[7:0];
          ext_addr_data_bus_oe <= 1'b1;
          ext_upper_addr       <= ex_req_r.addr[11:8];
        end
        EX_HOLD: begin
          // address stays on the bus while the latch closes
          ext_ale <= 1'b0;
        end
        EX_STROBE: begin
          ext_cs_n             <= ~(4'h1 << ex_req_r.cs);
          ext_read_n           <= ex_req_r.write;
          ext_write_n          <= ~ex_req_r.write;
          ext_addr_data_bus_o  <= ex_req_r.wdata;
          ext_addr_data_bus_oe <= ex_req_r.write;
          // late sample: synchroniser delay sits inside the strobe
          if (ex_ph_r == 3'h0 && !ex_req_r.write) begin
            ext_rsp.rdata <= sync_r[SY_AD +: 8];
          end
        end
        default: begin
          ext_ale              <= 1'b0;
          ext_addr_data_bus_oe <= 1'b0;
          ext_read_n           <= 1'b1;
          ext_write_n          <= 1'b1;
          ext_cs_n             <= 4'hF;
        end
      endcase
    end
  end

  assign sel_nxt = pick_drive(drive_sel);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_select_n <= 3'h7;
    end else begin
      drive_select_n <= ~sel_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_n <= 6'h3F;
    end else begin
      led_n <= ~{sel_nxt, led_user};
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      card_present <= 3'h0;
    end else begin
      card_present <= ~sync_r[SY_CD +: NUM_DRV];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_busy        <= 1'b0;
      spi_done        <= 1'b0;
      spi_rx          <= 8'h00;
      spi_div_r       <= 6'h00;
      spi_edge_r      <= 5'h00;
      spi_txsh_r      <= 8'h00;
      spi_rxsh_r      <= 8'h00;
      sd_serial_clock <= 1'b0;
      sd_serial_out   <= 1'b1;
    end else begin
      spi_done <= 1'b0;
      if (!spi_busy) begin
        if (spi_start) begin
          spi_busy      <= 1'b1;
          spi_div_r     <= SPI_HALF_CYC - 6'h01;
          spi_edge_r    <= 5'h00;
          spi_txsh_r    <= {spi_tx[6:0], 1'b0};
          sd_serial_out <= spi_tx[7];
        end
      end else if (spi_div_r != 6'h00) begin
        spi_div_r <= spi_div_r - 6'h01;
      end else begin
        spi_div_r       <= SPI_HALF_CYC - 6'h01;
        sd_serial_clock <= ~sd_serial_clock;
        spi_edge_r      <= spi_edge_r + 5'h01;
        if (!sd_serial_clock) begin
          spi_rxsh_r <= {spi_rxsh_r[6:0], sync_r[SY_MISO]};
        end else if (spi_edge_r == SPI_EDGES - 5'h01) begin
          spi_busy <= 1'b0;
          spi_done <= 1'b1;
          spi_rx   <= spi_rxsh_r;
        end else begin
          sd_serial_out <= spi_txsh_r[7];
          spi_txsh_r    <= {spi_txsh_r[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// [bench/pio_front_assertions.sv]
/*
  Port checker for pio_front, bound into every instance.
  Assumes one ref_clk domain and sys_rst asynchronous, active high.
*/
`timescale 1ns/100ps
module pio_front_assertions
  import pio_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               sys_rst,
  input wire logic               pins_oe,
  input wire logic               ext_addr_data_bus_oe,
  input wire logic               driver_on,
  input wire logic               driver_enable_n,
  input wire logic               reset_out_n,
  input wire pio_ext_req_t       ext_req,
  input wire pio_ext_rsp_t       ext_rsp,
  input wire logic               ext_ale,
  input wire logic               ext_read_n,
  input wire logic               ext_write_n,
  input wire logic [3:0]         ext_cs_n,
  input wire logic [NUM_DRV-1:0] drive_select_n,
  input wire logic               overload_sense_n,
  input wire logic               overload_flag,
  input wire logic               power_fail_req,
  input wire logic               power_fail_flag,
  input wire logic               adc_strobe,
  input wire logic               adc_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // saturating count of cycles since reset release
  logic [12:0] rel_cnt_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) rel_cnt_r <= 13'h0000;
    else if (rel_cnt_r != 13'h1FFF) rel_cnt_r <= rel_cnt_r + 13'h0001;
  end

  // checked during reset itself, so no disable here
  property p_float;
    disable iff (1'b0) sys_rst |-> !pins_oe && !ext_addr_data_bus_oe;
  endproperty
  a_float: assert property (p_float) else $error("pins driven in reset");
  property p_drv_en;
    $rose(driver_on) |=> !driver_enable_n;
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver enable not low");
  property p_rst_out;
    (rel_cnt_r < 13'h0F96 |-> !reset_out_n) and (rel_cnt_r > 13'h0FAA |-> reset_out_n);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset output timing");
  property p_ext_done;
    ext_req.start && !ext_rsp.busy |-> ##9 ext_rsp.done;
  endproperty
  a_ext_done: assert property (p_ext_done) else $error("bus cycle length");
  property p_ale;
    ext_ale |-> ext_addr_data_bus_oe && ext_read_n && ext_write_n && (&ext_cs_n);
  endproperty
  a_ale: assert property (p_ale) else $error("address phase overlaps strobe");
  property p_strobe;
    !ext_read_n || !ext_write_n |-> ext_cs_n != 4'hF && !ext_ale && (ext_read_n || ext_write_n);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without select");
  property p_sel;
    $onehot0(~drive_select_n);
  endproperty
  a_sel: assert property (p_sel) else $error("two drives selected");
  property p_ovl;
    !overload_sense_n [*5] |-> overload_flag;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not flagged");
  property p_pf;
    power_fail_req |-> ##[0:1] power_fail_flag;
  endproperty
  a_pf: assert property (p_pf) else $error("power fail flag missing");
  property p_adc;
    adc_strobe |=> adc_ready;
  endproperty
  a_adc: assert property (p_adc) else $error("converter ready late");
  c_ext: cover property (ext_rsp.done && ext_read_n);
  c_pf: cover property (power_fail_req);
  c_rst: cover property ($rose(reset_out_n));
endmodule

bind pio_front pio_front_assertions u_pio_front_assertions (.*);

// [bench/pio_board_model.sv]
/*
  Board side: address latch with byte store, one card on the serial bus,
  update strap. Assumes the device pins come straight from pio_front.
*/
`timescale 1ns/100ps
module pio_board_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] ad_o,
  input  wire logic       ad_oe,
  input  wire logic       ext_ale,
  input  wire logic       ext_read_n,
  input  wire logic       ext_write_n,
  output logic [7:0]      ad_i,
  input  wire logic [2:0] drive_select_n,
  input  wire logic       sd_serial_clock,
  input  wire logic       sd_serial_out,
  output logic            sd_serial_in,
  input  wire logic [7:0] card_reply,
  output logic [7:0]      card_got,
  output logic            update_strap,
  input  wire logic       upd_req
);
  logic [7:0] addr_r;
  logic [7:0] mem_r [0:255];
  logic [7:0] last_r = 8'h00;
  logic [7:0] sh_r = 8'h00;
  logic       junk_r = 1'b0;
  wire        sel = ~&drive_select_n;
  always @(posedge ref_clk) begin
    if (ext_ale) addr_r <= ad_o;
    if (!ext_write_n) mem_r[addr_r] <= ad_o;
    if (ad_oe) last_r <= ad_o;
    junk_r <= ~junk_r;
  end
  // no pull-ups: a released bus shows the inverse of its last value
  assign ad_i = ad_oe ? ad_o : (!ext_read_n ? mem_r[addr_r] : ~last_r);
  always @(posedge sel) sh_r = card_reply;
  always @(posedge sd_serial_clock) if (sel) card_got <= {card_got[6:0], sd_serial_out};
  always @(negedge sd_serial_clock) if (sel) sh_r <= {sh_r[6:0], 1'b0};
  assign sd_serial_in = sel ? sh_r[7] : junk_r;
  assign update_strap = upd_req;
endmodule

// [bench/test_pio_front.sv]
/*
  Self-checking bench for pio_front with the board model.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
module test_pio_front;
  import pio_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b0, input_polarity_strap = 1'b0;
  logic        output_polarity_strap = 1'b0, driver_on = 1'b0, overload_clr = 1'b0;
  logic        overload_sense_n = 1'b1, power_fail_n = 1'b1, power_fail_ack = 1'b0;
  logic        adc_strobe = 1'b0, spi_start = 1'b0, upd_req = 1'b0;
  logic [15:0] digital_input_line = 16'h0000, dout_value = 16'h0000;
  logic [13:0] ao_value_0 = 14'h0000, ao_value_1 = 14'h0000;
  logic [9:0]  analog_input_0 = 10'h000, analog_input_1 = 10'h000;
  logic [2:0]  led_user = 3'h0, drive_sel = 3'h0, drive_card_detect = 3'h7;
  logic [7:0]  spi_tx = 8'h00, card_reply = 8'h3C, card_got;
  logic [3:0]  boot_switch = 4'hF;
  pio_ext_req_t ext_req = '0;
  pio_ext_rsp_t ext_rsp;
  pio_boot_t   boot_info;
  logic [15:0] din_active, digital_output_line;
  logic [9:0]  adc_result_0, adc_result_1;
  logic [7:0]  ext_addr_data_bus_i, ext_addr_data_bus_o, spi_rx;
  logic [5:0]  led_n;
  logic [3:0]  ext_upper_addr, ext_cs_n;
  logic [2:0]  drive_select_n, card_present;
  logic        pins_oe, driver_enable_n, overload_flag, power_fail_req, power_fail_flag;
  logic        reset_out_n, analog_out_pwm_0, analog_out_pwm_1, adc_ready, update_mode;
  logic        ext_addr_data_bus_oe, ext_ale, ext_read_n, ext_write_n;
  logic        spi_busy, spi_done, sd_serial_clock, sd_serial_out, sd_serial_in, update_strap;
  int          checks = 0, miscompares = 0;

  always #12.5 ref_clk = ~ref_clk;

  pio_front u_pio_front (.*);

  pio_board_model u_pio_board_model (.ref_clk, .ad_o(ext_addr_data_bus_o),
    .ad_oe(ext_addr_data_bus_oe), .ext_ale, .ext_read_n, .ext_write_n,
    .ad_i(ext_addr_data_bus_i), .drive_select_n, .sd_serial_clock, .sd_serial_out,
    .sd_serial_in, .card_reply, .card_got, .update_strap, .upd_req);

  task automatic tally_and_finish;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic fail_to;
    miscompares++;
    tally_and_finish();
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    tick(4);
    check(pins_oe, 0);
    check(reset_out_n, 0);
    sys_rst = 1'b0;
  endtask

  task automatic t_boot;
    logic [3:0] bc [5] = '{4'hF, 4'hE, 4'h1, 4'h0, 4'h5};
    logic [2:0] be [5] = '{3'h4, 3'h6, 3'h5, 3'h7, 3'h4};
    for (int i = 0; i < 5; i++) begin
      boot_switch = bc[i];
      do_reset();
      tick(8);
      check(boot_info, be[i]);
      boot_switch = ~bc[i];
      tick(4);
      check(boot_info, be[i]);
    end
    $display("boot test done");
  endtask
  task automatic t_rstout;
    int n = 0;
    do_reset();
    while (reset_out_n !== 1'b1) begin
      tick(1);
      if (++n > 5000) fail_to();
    end
    check(32'(n > 3990 && n < 4010), 1);
    $display("reset out test done");
  endtask
  task automatic t_io;
    for (int p = 0; p < 2; p++) begin
      input_polarity_strap = p[0];
      output_polarity_strap = p[0];
      digital_input_line = 16'hA5C3;
      dout_value = 16'h3C96;
      driver_on = p[0];
      upd_req = p[0];
      led_user = 3'h5;
      drive_card_detect = p[0] ? 3'h2 : 3'h5;
      tick(6);
      check(pins_oe, 1);
      check(din_active, p[0] ? 16'hA5C3 : 16'h5A3C);
      check(digital_output_line, p[0] ? 16'h3C96 : 16'hC369);
      check(driver_enable_n, !p[0]);
      check(led_n[2:0], 3'h2);
      check(update_mode, p[0]);
      check(card_present, p[0] ? 3'h5 : 3'h2);
    end
    $display("io test done");
  endtask
  task automatic ext_xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n = 0;
    ext_req = {1'b1, w, 2'h1, a, d};
    tick(1);
    ext_req.start = 1'b0;
    while (ext_rsp.done !== 1'b1) begin
      if (ext_ale === 1'b1) check(ext_upper_addr, a[11:8]);
      if (ext_read_n === 1'b0 || ext_write_n === 1'b0) check(ext_cs_n, 4'hD);
      tick(1);
      if (++n > 20) fail_to();
    end
  endtask
  task automatic t_ext;
    ext_xfer(1'b1, 12'h35A, 8'h6B);
    ext_xfer(1'b1, 12'h3A5, 8'h94);
    ext_xfer(1'b0, 12'h35A, 8'h00);
    check(ext_rsp.rdata, 8'h6B);
    ext_xfer(1'b0, 12'h3A5, 8'h00);
    check(ext_rsp.rdata, 8'h94);
    $display("extension bus test done");
  endtask
  task automatic t_spi;
    int n = 0;
    drive_sel = 3'h6;
    tick(2);
    check(drive_select_n, 3'h5);
    check(led_n[5:3], 3'h5);
    spi_tx = 8'hA5;
    spi_start = 1'b1;
    tick(1);
    spi_start = 1'b0;
    while (spi_done !== 1'b1) begin
      tick(1);
      if (++n > 2000) fail_to();
    end
    check(32'(n > 795 && n < 805), 1);
    check(spi_busy, 0);
    check(spi_rx, 8'h3C);
    check(card_got, 8'hA5);
    drive_sel = 3'h0;
    $display("card bus test done");
  endtask
  task automatic t_fault;
    int n = 0;
    analog_input_0 = 10'h3FF;
    analog_input_1 = 10'h155;
    adc_strobe = 1'b1;
    tick(1);
    adc_strobe = 1'b0;
    tick(2);
    check(adc_result_0, 10'h3FF);
    check(adc_result_1, 10'h155);
    overload_sense_n = 1'b0;
    tick(6);
    overload_sense_n = 1'b1;
    tick(6);
    check(overload_flag, 1);
    overload_clr = 1'b1;
    tick(1);
    overload_clr = 1'b0;
    tick(1);
    check(overload_flag, 0);
    power_fail_n = 1'b0;
    while (power_fail_req !== 1'b1) begin
      tick(1);
      if (++n > 8) fail_to();
    end
    power_fail_n = 1'b1;
    tick(6);
    check(power_fail_flag, 1);
    power_fail_ack = 1'b1;
    tick(1);
    power_fail_ack = 1'b0;
    tick(1);
    check(power_fail_flag, 0);
    $display("fault test done");
  endtask
  task automatic wait_pwm(input logic lvl);
    int n = 0;
    while (analog_out_pwm_0 !== lvl) begin
      tick(1);
      if (++n > 40000) fail_to();
    end
  endtask
  task automatic t_pwm;
    int hi = 0, lo = 0, bad = 0;
    // 2500 of 10000 gives three quarters high time
    ao_value_0 = 14'h09C4;
    ao_value_1 = 14'h0000;
    wait_pwm(1'b0);
    wait_pwm(1'b1);
    while (analog_out_pwm_0 === 1'b1 && hi < 20000) begin
      bad += (analog_out_pwm_1 !== 1'b1);
      hi++;
      tick(1);
    end
    while (analog_out_pwm_0 === 1'b0 && lo < 20000) begin
      bad += (analog_out_pwm_1 !== 1'b1);
      lo++;
      tick(1);
    end
    check(hi, 12000);
    check(hi + lo, 16000);
    check(bad, 0);
    $display("pwm test done");
  endtask

  initial begin
    #1;
    t_boot();
    t_rstout();
    t_io();
    t_ext();
    t_spi();
    t_fault();
    t_pwm();
    tally_and_finish();
  end
endmodule
